/* logic/term_reg_pkg.sv */
// Purpose: Shared constants for the terminal register access unit.
// Assumes: One system clock and a synchronous active-high reset.
// Notes: Register numbers are six-bit indices carried in the control byte.
package term_reg_pkg;
  localparam int unsigned CTRL_ACCESS_BIT = 7;
  localparam int unsigned CTRL_WRITE_BIT = 6;
  localparam int unsigned REG_NUM_W = 6;
  localparam logic [5:0] REG_FIRMWARE_VERSION = 6'h09;
  localparam logic [5:0] REG_WRITE_UNLOCK_CODE = 6'h1F;
  localparam logic [5:0] REG_FEATURE_CONFIG = 6'h20;
  localparam logic [5:0] REG_USER_SCALE_OFFSET = 6'h21;
  localparam logic [5:0] REG_USER_SCALE_GAIN = 6'h22;
  localparam logic [5:0] REG_THRESHOLD_ONE = 6'h23;
  localparam logic [5:0] REG_THRESHOLD_TWO = 6'h24;
  localparam logic [5:0] REG_FILTER_CUTOFF_SELECT = 6'h25;
  localparam logic [15:0] UNLOCK_CODE_WORD = 16'h1235;
  localparam logic [15:0] FEATURE_RESET = 16'h0902;
  localparam logic [15:0] GAIN_RESET = 16'h0400;
  localparam logic [15:0] CUTOFF_RESET = 16'h0100;
  localparam logic [15:0] CUTOFF_STEP_1 = 16'h0100;
  localparam logic [15:0] CUTOFF_STEP_2 = 16'h0200;
  localparam logic [15:0] CUTOFF_STEP_3 = 16'h0300;
  localparam logic [15:0] CUTOFF_STEP_4 = 16'h0400;
  localparam int unsigned FEAT_USER_SCALE_BIT = 0;
  localparam int unsigned FEAT_THR1_BIT = 9;
  localparam int unsigned FEAT_THR2_BIT = 10;
  localparam int unsigned FEAT_IIR_BIT = 11;
  localparam int unsigned GAIN_SHIFT = 10;
  localparam int unsigned STAT_THR1_BIT = 1;
  localparam int unsigned STAT_THR2_BIT = 2;
  localparam logic signed [15:0] SAT_MAX = 16'sh7FFF;
  localparam logic signed [15:0] SAT_MIN = -16'sh8000;
endpackage

/* logic/sample_path_if.sv */
// Purpose: Carries the active settings and sample flow to the sample path.
// Assumes: Single clock domain.
// Notes: The settings are the latched copy taken at restart.
`timescale 1ns/100ps
`default_nettype none
interface sample_path_if;
  logic [15:0] feature;
  logic [15:0] offset;
  logic [15:0] gain;
  logic [15:0] thr_one;
  logic [15:0] thr_two;
  logic [15:0] cutoff;
  logic sample_valid;
  logic [15:0] sample;
  logic [15:0] result;
  logic [1:0] limit_flags;
  modport ctrl (output feature, offset, gain, thr_one, thr_two, cutoff, sample_valid, sample,
                input result, limit_flags);
  modport path (input feature, offset, gain, thr_one, thr_two, cutoff, sample_valid, sample,
                output result, limit_flags);
endinterface
`default_nettype wire

/* logic/sample_path.sv */
// Purpose: Scaling, filtering and threshold checking of one channel.
// Assumes: Settings come from the latched active copy.
// Notes: Filter shift grows with the cut-off selection.
`timescale 1ns/100ps
`default_nettype none
module sample_path (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  sample_path_if.path sp
);
  logic signed [15:0] filt_ff;
  logic signed [15:0] result_ff;
  logic [1:0] flags_ff;
  logic signed [33:0] product;
  logic signed [33:0] scaled_value_stage;
  logic signed [15:0] scaled_sat;
  logic signed [15:0] user_gain_factor;
  logic signed [15:0] user_offset_term;
  logic [2:0] filt_shift;
  logic filt_on;
  logic signed [16:0] filt_diff;
  logic signed [15:0] nxt_filt;
  logic signed [15:0] stage_in;
  assign user_gain_factor = sp.gain;
  assign user_offset_term = sp.offset;
  assign product = 34'(signed'(sp.sample)) * 34'(user_gain_factor);
  assign scaled_value_stage = (product >>> term_reg_pkg::GAIN_SHIFT) +
                              34'(user_offset_term);
  assign scaled_sat = (scaled_value_stage > 34'(term_reg_pkg::SAT_MAX)) ? term_reg_pkg::SAT_MAX :
                      (scaled_value_stage < 34'(term_reg_pkg::SAT_MIN)) ? term_reg_pkg::SAT_MIN :
                      scaled_value_stage[15:0];
  assign stage_in = sp.feature[term_reg_pkg::FEAT_USER_SCALE_BIT] ? scaled_sat :
                    signed'(sp.sample);
  assign filt_shift = (sp.cutoff == term_reg_pkg::CUTOFF_STEP_1) ? 3'h1 :
                      (sp.cutoff == term_reg_pkg::CUTOFF_STEP_2) ? 3'h2 :
                      (sp.cutoff == term_reg_pkg::CUTOFF_STEP_3) ? 3'h3 :
                      (sp.cutoff == term_reg_pkg::CUTOFF_STEP_4) ? 3'h4 : 3'h0;
  assign filt_on = sp.feature[term_reg_pkg::FEAT_IIR_BIT] && (filt_shift != 3'h0);
  assign filt_diff = 17'(stage_in) - 17'(filt_ff);
  assign nxt_filt = filt_on ? 16'(filt_ff + 16'(filt_diff >>> filt_shift)) : stage_in;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      filt_ff <= 16'sh0000;
      result_ff <= 16'sh0000;
      flags_ff <= 2'h0;
    end else if (sp.sample_valid) begin
      filt_ff <= nxt_filt;
      result_ff <= nxt_filt;
      flags_ff[0] <= sp.feature[term_reg_pkg::FEAT_THR1_BIT] &&
                     (nxt_filt > signed'(sp.thr_one));
      flags_ff[1] <= sp.feature[term_reg_pkg::FEAT_THR2_BIT] &&
                     (nxt_filt > signed'(sp.thr_two));
    end
  end
  assign sp.result = result_ff;
  assign sp.limit_flags = flags_ff;
  passthru_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    sp.sample_valid && !filt_on && !sp.feature[term_reg_pkg::FEAT_USER_SCALE_BIT]
    |=> sp.result == $past(sp.sample)) else $error("unfiltered sample not passed");
endmodule
`default_nettype wire

/* logic/terminal_register_access_unit.sv */
// Purpose: Register access over control byte and 16-bit data words for one channel.
// Assumes: One exchange per cycle with xfer_valid_i; restart_i models a power cycle.
// Notes: Settings written become active only at restart.
`timescale 1ns/100ps
`default_nettype none
module terminal_register_access_unit #(
  parameter logic [15:0] FIRMWARE_VERSION = 16'h3130 // Value is arbitrary.
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic xfer_valid_i,
  input wire logic [7:0] control_byte_i,
  input wire logic [15:0] outbound_word_i,
  input wire logic restart_i,
  input wire logic sample_valid_i,
  input wire logic [15:0] sample_i,
  output logic [7:0] status_byte_o,
  output logic [15:0] inbound_word_o,
  output logic xfer_done_o
);
  sample_path_if sp ();
  logic [15:0] unlock_ff;
  logic [15:0] feature_ff;
  logic [15:0] offset_ff;
  logic [15:0] gain_ff;
  logic [15:0] thr_one_ff;
  logic [15:0] thr_two_ff;
  logic [15:0] cutoff_ff;
  logic [15:0] act_feature_ff;
  logic [15:0] act_offset_ff;
  logic [15:0] act_gain_ff;
  logic [15:0] act_thr_one_ff;
  logic [15:0] act_thr_two_ff;
  logic [15:0] act_cutoff_ff;
  logic [7:0] status_ff;
  logic [15:0] inbound_ff;
  logic done_ff;
  logic is_reg;
  logic is_write;
  logic [5:0] reg_num;
  logic unlocked;
  logic wr_unlock;
  logic wr_user;
  logic [15:0] rd_data;
  logic [7:0] nxt_status;
  logic [15:0] nxt_inbound;
  logic [7:0] proc_status;

  assign is_reg = xfer_valid_i && control_byte_i[term_reg_pkg::CTRL_ACCESS_BIT];
  assign is_write = control_byte_i[term_reg_pkg::CTRL_WRITE_BIT];
  assign reg_num = control_byte_i[term_reg_pkg::REG_NUM_W-1:0];
  assign unlocked = (unlock_ff == term_reg_pkg::UNLOCK_CODE_WORD);
  assign wr_unlock = is_reg && is_write && (reg_num == term_reg_pkg::REG_WRITE_UNLOCK_CODE);
  assign wr_user = is_reg && is_write && unlocked;

  always_comb begin
    case (reg_num)
      term_reg_pkg::REG_FIRMWARE_VERSION: rd_data = FIRMWARE_VERSION;
      term_reg_pkg::REG_WRITE_UNLOCK_CODE: rd_data = unlock_ff;
      term_reg_pkg::REG_FEATURE_CONFIG: rd_data = feature_ff;
      term_reg_pkg::REG_USER_SCALE_OFFSET: rd_data = offset_ff;
      term_reg_pkg::REG_USER_SCALE_GAIN: rd_data = gain_ff;
      term_reg_pkg::REG_THRESHOLD_ONE: rd_data = thr_one_ff;
      term_reg_pkg::REG_THRESHOLD_TWO: rd_data = thr_two_ff;
      term_reg_pkg::REG_FILTER_CUTOFF_SELECT: rd_data = cutoff_ff;
      default: rd_data = 16'h0000;
    endcase
  end

  assign proc_status = {5'h00, sp.limit_flags[1], sp.limit_flags[0], 1'b0};
  assign nxt_status = !is_reg ? proc_status :
                      is_write ? {1'b1, 1'b0, control_byte_i[5:0]} : control_byte_i;
  assign nxt_inbound = !is_reg ? sp.result : is_write ? inbound_ff : rd_data;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      status_ff <= 8'h00;
      inbound_ff <= 16'h0000;
      done_ff <= 1'b0;
    end else begin
      done_ff <= xfer_valid_i;
      if (xfer_valid_i) begin
        status_ff <= nxt_status;
        inbound_ff <= nxt_inbound;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      unlock_ff <= 16'h0000;
    end else if (wr_unlock) begin
      unlock_ff <= outbound_word_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      feature_ff <= term_reg_pkg::FEATURE_RESET;
      offset_ff <= 16'h0000;
      gain_ff <= term_reg_pkg::GAIN_RESET;
      thr_one_ff <= 16'h0000;
      thr_two_ff <= 16'h0000;
      cutoff_ff <= term_reg_pkg::CUTOFF_RESET;
    end else if (wr_user) begin
      case (reg_num)
        term_reg_pkg::REG_FEATURE_CONFIG: feature_ff <= outbound_word_i;
        term_reg_pkg::REG_USER_SCALE_OFFSET: offset_ff <= outbound_word_i;
        term_reg_pkg::REG_USER_SCALE_GAIN: gain_ff <= outbound_word_i;
        term_reg_pkg::REG_THRESHOLD_ONE: thr_one_ff <= outbound_word_i;
        term_reg_pkg::REG_THRESHOLD_TWO: thr_two_ff <= outbound_word_i;
        term_reg_pkg::REG_FILTER_CUTOFF_SELECT: cutoff_ff <= outbound_word_i;
        default: feature_ff <= feature_ff;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || restart_i) begin
      act_feature_ff <= sys_rst_i ? term_reg_pkg::FEATURE_RESET : feature_ff;
      act_offset_ff <= sys_rst_i ? 16'h0000 : offset_ff;
      act_gain_ff <= sys_rst_i ? term_reg_pkg::GAIN_RESET : gain_ff;
      act_thr_one_ff <= sys_rst_i ? 16'h0000 : thr_one_ff;
      act_thr_two_ff <= sys_rst_i ? 16'h0000 : thr_two_ff;
      act_cutoff_ff <= sys_rst_i ? term_reg_pkg::CUTOFF_RESET : cutoff_ff;
    end
  end

  assign sp.feature = act_feature_ff;
  assign sp.offset = act_offset_ff;
  assign sp.gain = act_gain_ff;
  assign sp.thr_one = act_thr_one_ff;
  assign sp.thr_two = act_thr_two_ff;
  assign sp.cutoff = act_cutoff_ff;
  assign sp.sample_valid = sample_valid_i;
  assign sp.sample = sample_i;

  sample_path u_path (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .sp(sp)
  );

  assign status_byte_o = status_ff;
  assign inbound_word_o = inbound_ff;
  assign xfer_done_o = done_ff;

  logic code_wr_seen;
  logic [15:0] code_seen_ff;
  assign code_wr_seen = xfer_valid_i && control_byte_i[term_reg_pkg::CTRL_ACCESS_BIT] &&
                        control_byte_i[term_reg_pkg::CTRL_WRITE_BIT] &&
                        (reg_num == term_reg_pkg::REG_WRITE_UNLOCK_CODE);
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      code_seen_ff <= 16'h0000;
    end else if (code_wr_seen) begin
      code_seen_ff <= outbound_word_i;
    end
  end

  sequence reg_read_s;
    xfer_valid_i && control_byte_i[term_reg_pkg::CTRL_ACCESS_BIT] &&
      !control_byte_i[term_reg_pkg::CTRL_WRITE_BIT];
  endsequence
  sequence reg_write_s;
    xfer_valid_i && control_byte_i[term_reg_pkg::CTRL_ACCESS_BIT] &&
      control_byte_i[term_reg_pkg::CTRL_WRITE_BIT];
  endsequence
  sequence proc_xfer_s;
    xfer_valid_i && !control_byte_i[term_reg_pkg::CTRL_ACCESS_BIT];
  endsequence
  sequence read_of_s(logic [5:0] num);
    reg_read_s ##0 (control_byte_i[term_reg_pkg::REG_NUM_W-1:0] == num);
  endsequence
  sequence write_of_s(logic [5:0] num);
    reg_write_s ##0 (control_byte_i[term_reg_pkg::REG_NUM_W-1:0] == num);
  endsequence
  sequence locked_write_s(logic [5:0] num);
    write_of_s(num) ##0 !unlocked;
  endsequence
  sequence open_write_s(logic [5:0] num);
    write_of_s(num) ##0 unlocked;
  endsequence
  sequence sample_s;
    sample_valid_i;
  endsequence

  read_echo_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    reg_read_s
    |=> status_byte_o == $past(control_byte_i))
    else $error("read echo wrong");
  write_ack_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    reg_write_s
    |=> status_byte_o == ($past(control_byte_i) & 8'hBF))
    else $error("write ack wrong");
  write_word_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    reg_write_s
    |=> $stable(inbound_word_o))
    else $error("input word changed on write");
  done_pulse_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    xfer_valid_i
    |=> xfer_done_o)
    else $error("exchange not answered");
  done_idle_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !xfer_valid_i
    |=> !xfer_done_o)
    else $error("answer without exchange");
  answer_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !xfer_valid_i
    |=> $stable(status_byte_o) && $stable(inbound_word_o))
    else $error("answer changed without exchange");
  proc_kind_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    proc_xfer_s
    |=> !status_byte_o[term_reg_pkg::CTRL_ACCESS_BIT] && !status_byte_o[0])
    else $error("process status marked as register");
  proc_word_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    proc_xfer_s
    |=> inbound_word_o == $past(sp.result))
    else $error("process word wrong");
  status_thr_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    proc_xfer_s
    |=> status_byte_o[term_reg_pkg::STAT_THR1_BIT] == $past(sp.limit_flags[0]) &&
        status_byte_o[term_reg_pkg::STAT_THR2_BIT] == $past(sp.limit_flags[1]))
    else $error("threshold bits wrong");

  fw_read_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    read_of_s(term_reg_pkg::REG_FIRMWARE_VERSION)
    |=> inbound_word_o == FIRMWARE_VERSION)
    else $error("firmware read wrong");
  unlock_readback_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    read_of_s(term_reg_pkg::REG_WRITE_UNLOCK_CODE)
    |=> inbound_word_o == $past(code_seen_ff))
    else $error("code word readback wrong");
  feature_read_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    read_of_s(term_reg_pkg::REG_FEATURE_CONFIG)
    |=> inbound_word_o == $past(feature_ff))
    else $error("feature read wrong");
  offset_read_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    read_of_s(term_reg_pkg::REG_USER_SCALE_OFFSET)
    |=> inbound_word_o == $past(offset_ff))
    else $error("offset read wrong");
  gain_read_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    read_of_s(term_reg_pkg::REG_USER_SCALE_GAIN)
    |=> inbound_word_o == $past(gain_ff))
    else $error("gain read wrong");
  thr_one_read_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    read_of_s(term_reg_pkg::REG_THRESHOLD_ONE)
    |=> inbound_word_o == $past(thr_one_ff))
    else $error("threshold one read wrong");
  thr_two_read_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    read_of_s(term_reg_pkg::REG_THRESHOLD_TWO)
    |=> inbound_word_o == $past(thr_two_ff))
    else $error("threshold two read wrong");
  cutoff_read_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    read_of_s(term_reg_pkg::REG_FILTER_CUTOFF_SELECT)
    |=> inbound_word_o == $past(cutoff_ff))
    else $error("cut-off read wrong");
  unmapped_read_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    read_of_s(6'h3F)
    |=> inbound_word_o == 16'h0000)
    else $error("unmapped read not zero");
  read_quiet_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    reg_read_s
    |=> $stable(feature_ff) && $stable(gain_ff) && $stable(unlock_ff))
    else $error("read changed a register");

  lock_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    locked_write_s(term_reg_pkg::REG_FEATURE_CONFIG)
    |=> $stable(feature_ff))
    else $error("protected register changed");
  lock_thr_one_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    locked_write_s(term_reg_pkg::REG_THRESHOLD_ONE)
    |=> $stable(thr_one_ff))
    else $error("protected threshold changed");
  lock_all_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    reg_write_s ##0 !unlocked
    |=> $stable(feature_ff) && $stable(offset_ff) && $stable(gain_ff) &&
        $stable(thr_one_ff) && $stable(thr_two_ff) && $stable(cutoff_ff))
    else $error("protected register changed");
  open_feature_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    open_write_s(term_reg_pkg::REG_FEATURE_CONFIG)
    |=> feature_ff == $past(outbound_word_i))
    else $error("feature write lost");
  open_offset_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    open_write_s(term_reg_pkg::REG_USER_SCALE_OFFSET)
    |=> offset_ff == $past(outbound_word_i))
    else $error("offset write lost");
  open_gain_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    open_write_s(term_reg_pkg::REG_USER_SCALE_GAIN)
    |=> gain_ff == $past(outbound_word_i))
    else $error("gain write lost");
  open_cutoff_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    open_write_s(term_reg_pkg::REG_FILTER_CUTOFF_SELECT)
    |=> cutoff_ff == $past(outbound_word_i))
    else $error("cut-off write lost");
  unlock_code_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    write_of_s(term_reg_pkg::REG_WRITE_UNLOCK_CODE) ##0
    (outbound_word_i == term_reg_pkg::UNLOCK_CODE_WORD)
    |=> unlocked)
    else $error("code word did not unlock");
  relock_code_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    write_of_s(term_reg_pkg::REG_WRITE_UNLOCK_CODE) ##0
    (outbound_word_i != term_reg_pkg::UNLOCK_CODE_WORD)
    |=> !unlocked)
    else $error("protection not restored");
  code_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !code_wr_seen
    |=> $stable(unlock_ff))
    else $error("code word changed without write");

  active_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !restart_i
    |=> $stable(act_feature_ff) && $stable(act_gain_ff) && $stable(act_offset_ff) &&
        $stable(act_thr_one_ff) && $stable(act_thr_two_ff) && $stable(act_cutoff_ff))
    else $error("setting took effect early");
  active_copy_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    restart_i
    |=> act_feature_ff == $past(feature_ff) && act_gain_ff == $past(gain_ff) &&
        act_cutoff_ff == $past(cutoff_ff))
    else $error("restart did not apply settings");
  thr_one_off_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    sample_s ##0 !sp.feature[term_reg_pkg::FEAT_THR1_BIT]
    |=> !sp.limit_flags[0])
    else $error("disabled threshold one flagged");
  thr_two_off_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    sample_s ##0 !sp.feature[term_reg_pkg::FEAT_THR2_BIT]
    |=> !sp.limit_flags[1])
    else $error("disabled threshold two flagged");
endmodule
`default_nettype wire

/* verif/coupler_model.sv */
// Purpose: Bus coupler side that presents one exchange and collects the answer.
// Assumes: One exchange per xfer call; the answer comes within a few cycles.
// Notes: On reads the output word is scrambled, since the device must ignore it.
`timescale 1ns/100ps
`default_nettype none
module coupler_model (
  input wire logic ref_clk_i,
  input wire logic xfer_done_i,
  input wire logic [7:0] status_byte_i,
  input wire logic [15:0] inbound_word_i,
  output logic xfer_valid_o,
  output logic [7:0] control_byte_o,
  output logic [15:0] outbound_word_o
);
  initial begin
    xfer_valid_o = 1'b0;
    control_byte_o = 8'h00;
    outbound_word_o = 16'h0000;
  end
  task automatic xfer(input logic [7:0] c, input logic [15:0] w, output logic [7:0] st,
                      output logic [15:0] iw, output bit ok);
    @(posedge ref_clk_i);
    xfer_valid_o <= 1'b1;
    control_byte_o <= c;
    outbound_word_o <= c[6] ? w : ~outbound_word_o;
    @(posedge ref_clk_i);
    xfer_valid_o <= 1'b0;
    control_byte_o <= ~c;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (xfer_done_i === 1'b1) begin
        ok = 1'b1;
        st = status_byte_i;
        iw = inbound_word_i;
      end else begin
        @(posedge ref_clk_i);
      end
    end
  endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: Register and process exchanges against the access unit.
// Assumes: Coupler model issues exchanges; bench drives samples and restart.
// Notes: Reset values, the code word and saturation limits come from the package constants; the rest are set in the bench.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic ref_clk_i, sys_rst_i, restart_i, sample_valid_i, xfer_valid, xfer_done;
  logic [15:0] sample_i, outbound_word, inbound_word;
  logic [7:0] control_byte, status_byte;
  int mismatches, n_tests;
  localparam logic [15:0] FW = 16'h4142; // Value is arbitrary.
  terminal_register_access_unit #(.FIRMWARE_VERSION(FW)) dut_u (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .xfer_valid_i(xfer_valid),
    .control_byte_i(control_byte), .outbound_word_i(outbound_word), .restart_i(restart_i),
    .sample_valid_i(sample_valid_i), .sample_i(sample_i), .status_byte_o(status_byte),
    .inbound_word_o(inbound_word), .xfer_done_o(xfer_done));
  coupler_model coupler_u (
    .ref_clk_i(ref_clk_i), .xfer_done_i(xfer_done), .status_byte_i(status_byte),
    .inbound_word_i(inbound_word), .xfer_valid_o(xfer_valid),
    .control_byte_o(control_byte), .outbound_word_o(outbound_word));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic final_report();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic op(input logic [7:0] c, input logic [15:0] w, input logic [7:0] es,
                    input logic [15:0] ei, input bit ci);
    logic [7:0] st;
    logic [15:0] iw;
    bit ok;
    coupler_u.xfer(c, w, st, iw, ok);
    if (!ok) begin
      mismatches++;
      $display("[FAIL] %0t no answer to control %h", $time, c);
      final_report();
    end
    chk({8'h00, st}, {8'h00, es}, "status byte");
    if (ci) chk(iw, ei, "input word");
  endtask
  task automatic rd(input logic [5:0] r, input logic [15:0] e);
    op({2'b10, r}, 16'h0000, {2'b10, r}, e, 1'b1);
  endtask
  task automatic wr(input logic [5:0] r, input logic [15:0] v);
    op({2'b11, r}, v, {2'b10, r}, 16'h0000, 1'b0);
  endtask
  task automatic proc(input logic [15:0] s, input logic [7:0] es, input logic [15:0] ei,
                      input bit ci);
    @(posedge ref_clk_i);
    sample_valid_i <= 1'b1;
    sample_i <= s;
    @(posedge ref_clk_i);
    sample_valid_i <= 1'b0;
    op(8'h40, 16'h1235, es, ei, ci);
  endtask
  initial begin
    logic [5:0] ra [6];
    logic [15:0] va [6];
    ra = '{term_reg_pkg::REG_FEATURE_CONFIG, term_reg_pkg::REG_USER_SCALE_OFFSET,
           term_reg_pkg::REG_USER_SCALE_GAIN, term_reg_pkg::REG_THRESHOLD_ONE,
           term_reg_pkg::REG_THRESHOLD_TWO, term_reg_pkg::REG_FILTER_CUTOFF_SELECT};
    va = '{16'h0601, 16'h0010, 16'h0800, 16'h0100, 16'h0200, 16'h0300};
    mismatches = 0;
    n_tests = 0;
    sys_rst_i = 1'b1;
    restart_i = 1'b0;
    sample_valid_i = 1'b0;
    sample_i = 16'h0000;
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(term_reg_pkg::REG_FEATURE_CONFIG, term_reg_pkg::FEATURE_RESET);
    rd(term_reg_pkg::REG_USER_SCALE_OFFSET, 16'h0000);
    rd(term_reg_pkg::REG_USER_SCALE_GAIN, term_reg_pkg::GAIN_RESET);
    rd(term_reg_pkg::REG_THRESHOLD_ONE, 16'h0000);
    rd(term_reg_pkg::REG_THRESHOLD_TWO, 16'h0000);
    rd(term_reg_pkg::REG_FILTER_CUTOFF_SELECT, term_reg_pkg::CUTOFF_RESET);
    rd(term_reg_pkg::REG_WRITE_UNLOCK_CODE, 16'h0000);
    rd(term_reg_pkg::REG_FIRMWARE_VERSION, FW);
    rd(6'h3F, 16'h0000);
    wr(term_reg_pkg::REG_FEATURE_CONFIG, 16'h0055);
    rd(term_reg_pkg::REG_FEATURE_CONFIG, term_reg_pkg::FEATURE_RESET);
    wr(term_reg_pkg::REG_WRITE_UNLOCK_CODE, term_reg_pkg::UNLOCK_CODE_WORD);
    rd(term_reg_pkg::REG_WRITE_UNLOCK_CODE, term_reg_pkg::UNLOCK_CODE_WORD);
    wr(term_reg_pkg::REG_FIRMWARE_VERSION, 16'h0000);
    rd(term_reg_pkg::REG_FIRMWARE_VERSION, FW);
    for (int i = 0; i < 6; i++) begin
      wr(ra[i], va[i]);
      rd(ra[i], va[i]);
    end
    proc(16'h0100, 8'h00, 16'h0080, 1'b1);
    @(posedge ref_clk_i);
    restart_i <= 1'b1;
    @(posedge ref_clk_i);
    restart_i <= 1'b0;
    proc(16'h0100, 8'h06, 16'h0210, 1'b1);
    proc(16'h0040, 8'h00, 16'h0090, 1'b1);
    proc(16'h7000, 8'h06, term_reg_pkg::SAT_MAX, 1'b1);
    proc(16'h8000, 8'h00, term_reg_pkg::SAT_MIN, 1'b1);
    wr(term_reg_pkg::REG_WRITE_UNLOCK_CODE, 16'h0000);
    wr(term_reg_pkg::REG_THRESHOLD_ONE, 16'h7777);
    rd(term_reg_pkg::REG_THRESHOLD_ONE, 16'h0100);
    final_report();
  end
endmodule
`default_nettype wire
